//--- shared/pagsm_pkg.sv
// ==========================================================================
// shared constants for the port a / port c pin multiplexer
// ==========================================================================
package pagsm_pkg;

  // ========================================================================
  // bus geometry
  // ========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = ADDR_W - 2;
  localparam int BE_W   = DATA_W / 8;
  localparam int REG_W  = 8;

  // ========================================================================
  // register indices; byte address is four times the index
  // ========================================================================
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA      = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RESERVED_ONE     = 6'h01;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 6'h02;
  localparam logic [IDX_W-1:0] IDX_RESERVED_THREE   = 6'h03;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DATA      = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 6'h06;

  // ========================================================================
  // pin counts and peripheral bit positions
  // ========================================================================
  localparam int PA_WIDTH = 6;
  localparam int PC_WIDTH = 2;
  localparam int SPI_W    = 4;
  localparam int SPI_SS   = 3;
  localparam int SPI_SCK  = 2;
  localparam int SPI_MOSI = 1;
  localparam int SPI_MISO = 0;
  localparam int PC_CLK   = 0;
  localparam int PC_INT   = 1;
  localparam int BE_LOW   = 0;

  // ========================================================================
  // reset values
  // ========================================================================
  localparam logic [REG_W-1:0]  RST_REG  = 8'h00;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

  // ========================================================================
  // bus handshake states
  // ========================================================================
  typedef enum logic [1:0] {
    PAGSM_IDLE = 2'b01,
    PAGSM_ACK  = 2'b10
  } pagsm_bus_t;

endpackage

//--- rtl/pagsm_sync.sv
`timescale 1ns/1ps
// ==========================================================================
// two stage pin synchroniser
// ==========================================================================
module pagsm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pins and synchronised levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage_one;
  logic [W-1:0] next_stage_one;
  logic [W-1:0] next_sync_out;

  always_comb
  begin
    next_stage_one = async_in;
    next_sync_out  = stage_one;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage_one <= '0;
      sync_out  <= '0;
    end
    else
    begin
      stage_one <= next_stage_one;
      sync_out  <= next_sync_out;
    end
  end

endmodule

//--- rtl/pagsm_top.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Overview of operation
// - data read returns latch where direction is 1, else synchronised pin
// - port a bits 3..0 carry spi ss, sck, mosi, miso when spi uses them
// - pins not used by their peripheral behave as plain gpio
// - reserved slots one and three read zero, writes change nothing
// - gpio pin drives when direction bit is 1, else high impedance input
// - spi decides direction of owned pins; stored direction bit unchanged
// - direction register holds bits 5..0, bits 7..6 read zero, any time
// - port c data register readable and writable at any time
// - port c pin 1 is link interrupt input, pin 0 link clock output
module pagsm_top
  import pagsm_pkg::*;
#(
  parameter int PA_W = PA_WIDTH,
  parameter int PC_W = PC_WIDTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [BE_W-1:0]   byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // port a pins
  input  wire logic [PA_W-1:0]   pa_pin_in,
  output logic      [PA_W-1:0]   pa_pin_out,
  output logic      [PA_W-1:0]   pa_pin_oe,
  // spi peripheral side
  input  wire logic [SPI_W-1:0]  spi_pin_owned,
  input  wire logic [SPI_W-1:0]  spi_pin_drive,
  input  wire logic [SPI_W-1:0]  spi_pin_drive_oe,
  output logic      [SPI_W-1:0]  spi_pin_level,
  // port c pins
  input  wire logic [PC_W-1:0]   pc_pin_in,
  output logic      [PC_W-1:0]   pc_pin_out,
  output logic      [PC_W-1:0]   pc_pin_oe,
  // die link side
  input  wire logic              die_link_clock_enable,
  input  wire logic              die_link_clock_out,
  input  wire logic              die_link_interrupt_enable,
  output logic                   die_link_interrupt_in
);

  // ========================================================================
  // decoding helpers
  // ========================================================================
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [IDX_W-1:0]  idx);
    reg_hit = (a[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic [REG_W-1:0] readback(
    input logic [REG_W-1:0] latch,
    input logic [REG_W-1:0] dir,
    input logic [REG_W-1:0] pin);
    readback = (latch & dir) | (pin & ~dir);
  endfunction

  // ========================================================================
  // pin synchronisers
  // ========================================================================
  logic [PA_W-1:0] pa_sync;
  logic [PC_W-1:0] pc_sync;

  pagsm_sync #(.W(PA_W)) u_pa_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pa_pin_in),
    .sync_out (pa_sync)
  );

  pagsm_sync #(.W(PC_W)) u_pc_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pc_pin_in),
    .sync_out (pc_sync)
  );

  // ========================================================================
  // registers and bus handshake
  // ========================================================================
  pagsm_bus_t        state;
  pagsm_bus_t        next_state;
  logic [PA_W-1:0]   port_a_data;
  logic [PA_W-1:0]   next_port_a_data;
  logic [PA_W-1:0]   port_a_direction;
  logic [PA_W-1:0]   next_port_a_direction;
  logic [PC_W-1:0]   port_c_data;
  logic [PC_W-1:0]   next_port_c_data;
  logic [PC_W-1:0]   port_c_direction;
  logic [PC_W-1:0]   next_port_c_direction;
  logic [DATA_W-1:0] next_readdata;
  logic [REG_W-1:0]  pa_rb;
  logic [REG_W-1:0]  pc_rb;
  logic              wr_commit;
  logic              wr_low;

  assign pa_rb = readback(REG_W'(port_a_data), REG_W'(port_a_direction),
                          REG_W'(pa_sync));
  assign pc_rb = readback(REG_W'(port_c_data), REG_W'(port_c_direction),
                          REG_W'(pc_sync));

  // one wait cycle, then the answer
  assign waitrequest = (read | write) & (state == PAGSM_IDLE);
  assign wr_commit   = write & (state == PAGSM_ACK);
  assign wr_low      = wr_commit & byteenable[BE_LOW];

  always_comb
  begin
    next_state            = state;
    next_readdata         = readdata;
    next_port_a_data      = port_a_data;
    next_port_a_direction = port_a_direction;
    next_port_c_data      = port_c_data;
    next_port_c_direction = port_c_direction;
    unique case (state)
      PAGSM_IDLE:
      begin
        if (read | write)
        begin
          next_state = PAGSM_ACK;
        end
        if (read)
        begin
          next_readdata = RST_DATA;
          if (reg_hit(address, IDX_PORT_A_DATA))
          begin
            next_readdata = DATA_W'(pa_rb[PA_W-1:0]);
          end
          if (reg_hit(address, IDX_PORT_A_DIRECTION))
          begin
            next_readdata = DATA_W'(port_a_direction);
          end
          if (reg_hit(address, IDX_PORT_C_DATA))
          begin
            next_readdata = DATA_W'(pc_rb[PC_W-1:0]);
          end
          if (reg_hit(address, IDX_PORT_C_DIRECTION))
          begin
            next_readdata = DATA_W'(port_c_direction);
          end
        end
      end
      PAGSM_ACK:
      begin
        next_state = PAGSM_IDLE;
      end
    endcase
    if (wr_low && reg_hit(address, IDX_PORT_A_DATA))
    begin
      next_port_a_data = writedata[PA_W-1:0];
    end
    if (wr_low && reg_hit(address, IDX_PORT_A_DIRECTION))
    begin
      next_port_a_direction = writedata[PA_W-1:0];
    end
    if (wr_low && reg_hit(address, IDX_PORT_C_DATA))
    begin
      next_port_c_data = writedata[PC_W-1:0];
    end
    if (wr_low && reg_hit(address, IDX_PORT_C_DIRECTION))
    begin
      next_port_c_direction = writedata[PC_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state            <= PAGSM_IDLE;
      readdata         <= RST_DATA;
      port_a_data      <= RST_REG[PA_W-1:0];
      port_a_direction <= RST_REG[PA_W-1:0];
      port_c_data      <= RST_REG[PC_W-1:0];
      port_c_direction <= RST_REG[PC_W-1:0];
    end
    else
    begin
      state            <= next_state;
      readdata         <= next_readdata;
      port_a_data      <= next_port_a_data;
      port_a_direction <= next_port_a_direction;
      port_c_data      <= next_port_c_data;
      port_c_direction <= next_port_c_direction;
    end
  end

  // ========================================================================
  // pin multiplexing
  // ========================================================================
  logic [PA_W-1:0] own_mask;
  logic [PA_W-1:0] spi_out_ext;
  logic [PA_W-1:0] spi_oe_ext;
  logic [PC_W-1:0] link_mask;
  logic [PC_W-1:0] link_out;
  logic [PC_W-1:0] link_oe;

  assign own_mask    = PA_W'(spi_pin_owned);
  assign spi_out_ext = PA_W'(spi_pin_drive);
  assign spi_oe_ext  = PA_W'(spi_pin_drive_oe);
  assign spi_pin_level = pa_sync[SPI_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < PA_W; gi = gi + 1)
    begin : g_pa
      assign pa_pin_out[gi] = own_mask[gi] ? spi_out_ext[gi]
                                           : port_a_data[gi];
      assign pa_pin_oe[gi]  = own_mask[gi] ? spi_oe_ext[gi]
                                           : port_a_direction[gi];
    end
  endgenerate

  // clock out on pin 0, interrupt in on pin 1
  always_comb
  begin
    link_mask         = '0;
    link_out          = '0;
    link_oe           = '0;
    link_mask[PC_CLK] = die_link_clock_enable;
    link_out[PC_CLK]  = die_link_clock_out;
    link_oe[PC_CLK]   = 1'b1;
    link_mask[PC_INT] = die_link_interrupt_enable;
  end

  assign pc_pin_out = (link_mask & link_out) | (~link_mask & port_c_data);
  assign pc_pin_oe  = (link_mask & link_oe)
                    | (~link_mask & port_c_direction);
  assign die_link_interrupt_in = die_link_interrupt_enable & pc_sync[PC_INT];

  // ========================================================================
  // checks
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [1:0] warm;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      warm <= 2'h0;
    end
    else if (warm != 2'h3)
    begin
      warm <= warm + 2'h1;
    end
  end

  sequence req_first;
    (state == PAGSM_IDLE) && (read || write);
  endsequence

  sequence req_done;
    !waitrequest;
  endsequence

  bus_wait_a: assert property (req_first |-> waitrequest ##1 req_done)
    else $error("bus answer not after one wait cycle");

  readback_pa_a: assert property (
    req_first ##0 read && reg_hit(address, IDX_PORT_A_DATA)
    |=> readdata == DATA_W'($past(pa_rb[PA_W-1:0])))
    else $error("port a read-back wrong");

  spi_route_a: assert property (
    spi_pin_owned[SPI_SS] |-> pa_pin_out[SPI_SS] == spi_pin_drive[SPI_SS]
      && pa_pin_oe[SPI_SS] == spi_pin_drive_oe[SPI_SS])
    else $error("ss not routed to spi");

  gpio_fallback_a: assert property (
    (pa_pin_out & ~own_mask) == (port_a_data & ~own_mask))
    else $error("free pin not driven from latch");

  rsvd_read_a: assert property (
    req_first ##0 read && (reg_hit(address, IDX_RESERVED_ONE)
      || reg_hit(address, IDX_RESERVED_THREE)) |=> readdata == RST_DATA)
    else $error("reserved slot read not zero");

  rsvd_write_a: assert property (
    wr_commit && (reg_hit(address, IDX_RESERVED_ONE)
      || reg_hit(address, IDX_RESERVED_THREE))
    |=> $stable(port_a_data) && $stable(port_a_direction)
      && $stable(port_c_data) && $stable(port_c_direction))
    else $error("reserved write changed state");

  gpio_dir_a: assert property (
    (pa_pin_oe & ~own_mask) == (port_a_direction & ~own_mask))
    else $error("gpio enable differs from direction");

  dir_kept_a: assert property (
    !$stable(spi_pin_owned) && !wr_commit |=> $stable(port_a_direction))
    else $error("direction changed by spi");

  dir_width_a: assert property (
    req_first ##0 read && reg_hit(address, IDX_PORT_A_DIRECTION)
    |=> readdata[DATA_W-1:PA_W] == '0
      && readdata[PA_W-1:0] == $past(port_a_direction))
    else $error("direction read wrong");

  pc_write_a: assert property (
    wr_low && reg_hit(address, IDX_PORT_C_DATA)
    |=> port_c_data == $past(writedata[PC_W-1:0]))
    else $error("port c write lost");

  link_clk_a: assert property (
    die_link_clock_enable |-> pc_pin_oe[PC_CLK]
      && pc_pin_out[PC_CLK] == die_link_clock_out)
    else $error("link clock not on pin 0");

  sync_lat_a: assert property (
    warm == 2'h3 |-> pa_sync == $past(pa_pin_in, 2))
    else $error("pin sync latency not two");

endmodule

//--- sim/pagsm_pin_model.sv
`timescale 1ns/1ps
// ==========================================================================
// far side of the pins: external drivers and wire resolution
// ==========================================================================
module pagsm_pin_model #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // design side of the pins
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  // external drivers
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_oe,
  // resolved pin level
  output logic      [W-1:0] pin_in
);
  logic [W-1:0] last;

  // an undriven wire shows the inverse of its last level, never a copy
  always_comb
  begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
           | (~pin_oe & ~ext_oe & ~last);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      last <= '0;
    else
      last <= pin_in;
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pagsm_pkg::*;
  // ========================================================================
  // signals
  // ========================================================================
  localparam logic [ADDR_W-1:0] A_PA  = {IDX_PORT_A_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_R1  = {IDX_RESERVED_ONE, 2'b00};
  localparam logic [ADDR_W-1:0] A_DIR = {IDX_PORT_A_DIRECTION, 2'b00};
  localparam logic [ADDR_W-1:0] A_R3  = {IDX_RESERVED_THREE, 2'b00};
  localparam logic [ADDR_W-1:0] A_PC  = {IDX_PORT_C_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_PCD = {IDX_PORT_C_DIRECTION, 2'b00};
  logic                clk;
  logic                reset_n;
  logic [ADDR_W-1:0]   address;
  logic                read;
  logic                write;
  logic [DATA_W-1:0]   writedata;
  logic [BE_W-1:0]     byteenable;
  logic [DATA_W-1:0]   readdata;
  logic [DATA_W-1:0]   rdata;
  logic                waitrequest;
  logic [PA_WIDTH-1:0] pa_pin_in;
  logic [PA_WIDTH-1:0] pa_pin_out;
  logic [PA_WIDTH-1:0] pa_pin_oe;
  logic [PA_WIDTH-1:0] ext_pa;
  logic [SPI_W-1:0]    spi_pin_owned;
  logic [SPI_W-1:0]    spi_pin_drive;
  logic [SPI_W-1:0]    spi_pin_drive_oe;
  logic [SPI_W-1:0]    spi_pin_level;
  logic [PC_WIDTH-1:0] pc_pin_in;
  logic [PC_WIDTH-1:0] pc_pin_out;
  logic [PC_WIDTH-1:0] pc_pin_oe;
  logic [PC_WIDTH-1:0] ext_pc;
  logic                die_link_clock_enable;
  logic                die_link_clock_out;
  logic                die_link_interrupt_enable;
  logic                die_link_interrupt_in;
  int                  failures;
  int                  cmp_count;
  logic [ADDR_W-1:0]   rst_addr [7];

  // ========================================================================
  // design and far side
  // ========================================================================
  pagsm_top i_pagsm_top (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pa_pin_in(pa_pin_in),
    .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
    .spi_pin_owned(spi_pin_owned), .spi_pin_drive(spi_pin_drive),
    .spi_pin_drive_oe(spi_pin_drive_oe), .spi_pin_level(spi_pin_level),
    .pc_pin_in(pc_pin_in), .pc_pin_out(pc_pin_out), .pc_pin_oe(pc_pin_oe),
    .die_link_clock_enable(die_link_clock_enable),
    .die_link_clock_out(die_link_clock_out),
    .die_link_interrupt_enable(die_link_interrupt_enable),
    .die_link_interrupt_in(die_link_interrupt_in));
  pagsm_pin_model #(.W(PA_WIDTH)) i_pagsm_pin_model (.clk(clk),
    .reset_n(reset_n), .pin_out(pa_pin_out), .pin_oe(pa_pin_oe),
    .ext_val(ext_pa), .ext_oe(6'h3F), .pin_in(pa_pin_in));
  pagsm_pin_model #(.W(PC_WIDTH)) i_pagsm_pin_model_c (.clk(clk),
    .reset_n(reset_n), .pin_out(pc_pin_out), .pin_oe(pc_pin_oe),
    .ext_val(ext_pc), .ext_oe(2'h3), .pin_in(pc_pin_in));

  // ========================================================================
  // tasks
  // ========================================================================
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_rd, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= is_rd;
    write      <= !is_rd;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      failures++;
    rdata = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ========================================================================
  // tests
  // ========================================================================
  initial
  begin
    clk = 1'b0; reset_n = 1'b0; address = '0; read = 1'b0; write = 1'b0;
    writedata = '0; byteenable = 4'hF; ext_pa = 6'h00; ext_pc = 2'h0;
    spi_pin_owned = 4'h0; spi_pin_drive = 4'h0; spi_pin_drive_oe = 4'h0;
    die_link_clock_enable = 1'b0; die_link_clock_out = 1'b0;
    die_link_interrupt_enable = 1'b0; failures = 0; cmp_count = 0;
    rst_addr = '{A_PA, A_R1, A_DIR, A_R3, A_PC, A_PCD, 8'h40};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rst_addr[i])
    begin
      bus(1'b1, rst_addr[i], '0, 4'hF);
      check(rdata, 32'h0);
    end
    bus(1'b0, A_DIR, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, A_DIR, '0, 4'hF);
    check(rdata, 32'h3F);
    bus(1'b0, A_PA, 32'h2A, 4'hF);
    bus(1'b1, A_PA, '0, 4'hF);
    check(rdata, 32'h2A);
    check(32'(pa_pin_oe), 32'h3F);
    check(32'(pa_pin_out), 32'h2A);
    bus(1'b0, A_R1, 32'hFF, 4'hF);
    bus(1'b0, A_R3, 32'hFF, 4'hF);
    bus(1'b0, A_DIR, 32'h00, 4'hE);
    bus(1'b1, A_R1, '0, 4'hF);
    check(rdata, 32'h0);
    bus(1'b1, A_R3, '0, 4'hF);
    check(rdata, 32'h0);
    bus(1'b1, A_DIR, '0, 4'hF);
    check(rdata, 32'h3F);
    ext_pa <= 6'h15;
    bus(1'b0, A_DIR, 32'h38, 4'hF);
    repeat (4) @(posedge clk);
    bus(1'b1, A_PA, '0, 4'hF);
    check(rdata, 32'h2D);
    check(32'(pa_pin_oe), 32'h38);
    spi_pin_owned <= 4'hF;
    spi_pin_drive <= 4'hF;
    spi_pin_drive_oe <= 4'h5;
    @(negedge clk);
    check(32'(pa_pin_oe), 32'h35);
    check(32'(pa_pin_out & pa_pin_oe), 32'h25);
    bus(1'b1, A_DIR, '0, 4'hF);
    check(rdata, 32'h38);
    repeat (3) @(posedge clk);
    check(32'(spi_pin_level), 32'h5);
    spi_pin_owned <= 4'h0;
    @(negedge clk);
    check(32'(pa_pin_oe), 32'h38);
    bus(1'b0, A_PCD, 32'h03, 4'hF);
    bus(1'b0, A_PC, 32'h02, 4'hF);
    bus(1'b1, A_PC, '0, 4'hF);
    check(rdata, 32'h02);
    check(32'(pc_pin_oe), 32'h3);
    check(32'(pc_pin_out), 32'h2);
    die_link_clock_enable <= 1'b1;
    die_link_clock_out <= 1'b1;
    die_link_interrupt_enable <= 1'b1;
    ext_pc <= 2'h2;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(32'(pc_pin_oe), 32'h1);
    check(32'(pc_pin_out[PC_CLK]), 32'h1);
    check(32'(die_link_interrupt_in), 32'h1);
    bus(1'b1, A_PCD, '0, 4'hF);
    check(rdata, 32'h03);
    die_link_interrupt_enable <= 1'b0;
    die_link_clock_enable <= 1'b0;
    @(negedge clk);
    check(32'(die_link_interrupt_in), 32'h0);
    check(32'(pc_pin_oe), 32'h3);
    bus(1'b0, A_PCD, 32'h00, 4'hF);
    bus(1'b1, A_PC, '0, 4'hF);
    check(rdata, 32'h02);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b1, A_DIR, '0, 4'hF);
    check(rdata, 32'h0);
    print_verdict();
  end

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
